// File: quad_dac_defines.svh
// constants for the quad dac serial command port
`ifndef QUAD_DAC_DEFINES_SVH
`define QUAD_DAC_DEFINES_SVH

// ****************************************
// word layout
// ****************************************
`define WORD_BITS      12
`define CODE_MSB       11
`define CODE_LSB       8
`define ADDR_MSB       11
`define ADDR_LSB       10
`define DATA_MSB       7
`define DATA_LSB       0
`define CODE_WIDTH     8
`define NUM_CHAN       4

// ****************************************
// command codes {addr_bit_hi, addr_bit_lo, ctrl_bit_hi, ctrl_bit_lo}
// ****************************************
`define CMD_PASS       4'h0
`define CMD_USER_LOW   4'h2
`define CMD_SW_UPDATE  4'h4
`define CMD_USER_HIGH  4'h6
`define CMD_LOAD_ALL   4'h8
`define CMD_MODE_FALL  4'hA
`define CMD_SHUTDOWN   4'hC
`define CMD_MODE_RISE  4'hE

// ****************************************
// reset values
// ****************************************
`define RST_SHIFT      12'h000
`define RST_CODE       8'h00
`define RST_MODE       1'b0
`define RST_USER       1'b0
`define RST_SHUTDOWN   1'b0
`define RST_DOUT       1'b0

`endif

// File: quad_dac_pkg.sv
// types shared by the quad dac serial command port
package quad_dac_pkg;
   `include "quad_dac_defines.svh"

   typedef logic [`CODE_WIDTH-1:0] code_t;

   typedef enum logic
   {
      DOUT_FALL_EDGE = 1'b0,
      DOUT_RISE_EDGE = 1'b1
   } dout_mode_e;

   typedef struct packed
   {
      code_t [`NUM_CHAN-1:0] in_code;
      code_t [`NUM_CHAN-1:0] dac;
   } chan_s;

   typedef struct packed
   {
      logic                  sclk_d;
      logic                  cs_n_d;
      logic [`WORD_BITS-1:0] shift;
      logic                  spill;
      logic                  dout;
      dout_mode_e            mode;
      logic                  user;
      logic                  shutdown;
      logic                  ld_one;
      logic                  ld_all;
      logic                  upd_all;
      logic [1:0]            addr;
      code_t                 data;
   } port_s;
endpackage

// File: pin_sync.sv
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module pin_sync
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             clk_in,
   input  wire logic             arst_n_in,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] stable_out
);
   typedef struct packed
   {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_s;

   sync_s st;
   sync_s next_st;

   // meta feeds only the second stage
   always_comb
   begin
      next_st.meta   = pin_in;
      next_st.stable = st.meta;
   end

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign stable_out = st.stable;
endmodule

// File: channel_regs.sv
// per-channel input and dac code registers
`timescale 1ns/1ps
module channel_regs
   import quad_dac_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        ld_one_in,
   input  wire logic        ld_all_in,
   input  wire logic        upd_all_in,
   input  wire logic        transparent_in,
   input  wire logic [1:0]  addr_in,
   input  wire code_t       data_in,
   output logic      [31:0] in_code_out,
   output logic      [31:0] dac_code_out
);
   chan_s st;
   chan_s next_st;

   always_comb
   begin
      next_st = st;
      for (int i = 0; i < `NUM_CHAN; i++)
      begin
         if (ld_all_in)
         begin
            next_st.in_code[i] = data_in;
            next_st.dac[i]     = data_in;
         end
         else if (ld_one_in && addr_in == 2'(i))
         begin
            next_st.in_code[i] = data_in;
         end
         // dac follows the freshly loaded input code
         if (upd_all_in || transparent_in)
         begin
            next_st.dac[i] = next_st.in_code[i];
         end
      end
   end

   // rst_n_in also carries the clear pin
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign in_code_out  = st.in_code;
   assign dac_code_out = st.dac;
endmodule

// File: quad_dac_serial_command_port.sv
// serial command port of a quad 8-bit dac, sampled on the system clock
//
// Operation
// - power-on clears the serial interface and every input and dac code.
// - after power-on the serial output changes on falling clock edges.
// - frames go msb first; of a 16-bit word only the last 12 count.
// - a bit is shifted in on each rising clock edge while select is low.
// - serial output repeats each bit 12 clocks later, on the chosen edge.
// - select high: interface ignored, serial output holds and never floats.
// - each select rise decodes the shift register; master sends 12 bits.
// - word is two address bits, two control bits, eight code bits.
// - address bits 00..11 pick channels a to d for loads.
// - control 01 loads the addressed input code, dacs unchanged.
// - control 11 loads the addressed input code then updates all dacs.
// - code 0100 copies all input codes to dacs and ends shutdown.
// - code 1000 loads all channels with the data and ends shutdown.
// - code 1100 enters shutdown only while shutdown permit is high.
// - code 0000 touches no code register; words just pass through.
// - code 1110 selects rising-edge output and updates all dacs.
// - code 1010 selects falling-edge output and updates all dacs.
// - code 0010 drives user output low, code 0110 drives it high.
// - the output edge mode holds until power-up or the other command.
// - while the load strobe is low the dacs follow their input codes.
// - the clear pin low clears all input and dac codes at once.
`timescale 1ns/1ps
module quad_dac_serial_command_port
   import quad_dac_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   input  wire logic        sclk_in,
   input  wire logic        din_in,
   input  wire logic        cs_n_in,
   input  wire logic        load_strobe_n_in,
   input  wire logic        async_clear_n_in,
   input  wire logic        shutdown_permit_in,
   output logic             dout_out,
   output logic             user_logic_out,
   output logic             shutdown_out,
   output logic             dout_mode_out,
   output logic      [31:0] dac_code_out
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [4:0] pins_s;
   logic       sclk_s;
   logic       din_s;
   logic       cs_n_s;
   logic       load_strobe_n_s;
   logic       shutdown_permit_s;

   pin_sync
   #(
      .WIDTH (5)
   )
   u_pin_sync
   (
      .clk_in     (clk_in),
      .arst_n_in  (arst_n_in),
      .pin_in     ({sclk_in, din_in, ~cs_n_in, ~load_strobe_n_in,
                    shutdown_permit_in}),
      .stable_out (pins_s)
   );

   // sclk and din share latency, so setup at the pin is preserved
   assign sclk_s            = pins_s[4];
   assign din_s             = pins_s[3];
   // active-low pins ride inverted, so a flushed stage reads as idle high
   // and no false select rise or load strobe follows reset
   assign cs_n_s            = ~pins_s[2];
   assign load_strobe_n_s   = ~pins_s[1];
   assign shutdown_permit_s = pins_s[0];

   // ****************************************
   // state and edge detection
   // ****************************************
   port_s      st;
   port_s      next_st;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       cs_rise;
   logic [3:0] cmd;
   logic [1:0] cmd_addr;
   code_t      cmd_data;

   assign sclk_rise = sclk_s & ~st.sclk_d;
   assign sclk_fall = ~sclk_s & st.sclk_d;
   assign cs_rise   = cs_n_s & ~st.cs_n_d;
   assign cmd       = st.shift[`CODE_MSB:`CODE_LSB];
   assign cmd_addr  = st.shift[`ADDR_MSB:`ADDR_LSB];
   assign cmd_data  = st.shift[`DATA_MSB:`DATA_LSB];

   // ****************************************
   // shifting, serial output and decode
   // ****************************************
   always_comb
   begin
      next_st         = st;
      next_st.sclk_d  = sclk_s;
      next_st.cs_n_d  = cs_n_s;
      next_st.ld_one  = 1'b0;
      next_st.ld_all  = 1'b0;
      next_st.upd_all = 1'b0;

      // nothing moves while select is high
      if (!cs_n_s && sclk_rise)
      begin
         // older bits fall off the top, so a 16-bit word keeps its last 12
         next_st.shift = {st.shift[`WORD_BITS-2:0], din_s};
         next_st.spill = st.shift[`WORD_BITS-1];
         if (st.mode == DOUT_RISE_EDGE)
         begin
            next_st.dout = st.shift[`WORD_BITS-1];
         end
      end
      if (!cs_n_s && sclk_fall && st.mode == DOUT_FALL_EDGE)
      begin
         // spill stage gives half a clock more lag in this mode
         next_st.dout = st.spill;
      end

      if (cs_rise)
      begin
         next_st.addr = cmd_addr;
         next_st.data = cmd_data;
         if (cmd[0])
         begin
            next_st.ld_one  = 1'b1;
            next_st.upd_all = cmd[1];
         end
         else
         begin
            unique case (cmd)
               `CMD_PASS:
               begin
                  next_st.ld_one = 1'b0;
               end
               `CMD_USER_LOW:
               begin
                  next_st.user = 1'b0;
               end
               `CMD_USER_HIGH:
               begin
                  next_st.user = 1'b1;
               end
               `CMD_SW_UPDATE:
               begin
                  next_st.upd_all  = 1'b1;
                  next_st.shutdown = 1'b0;
               end
               `CMD_LOAD_ALL:
               begin
                  next_st.ld_all   = 1'b1;
                  next_st.shutdown = 1'b0;
               end
               `CMD_SHUTDOWN:
               begin
                  if (shutdown_permit_s)
                  begin
                     next_st.shutdown = 1'b1;
                  end
               end
               `CMD_MODE_RISE:
               begin
                  next_st.mode    = DOUT_RISE_EDGE;
                  next_st.upd_all = 1'b1;
               end
               `CMD_MODE_FALL:
               begin
                  next_st.mode    = DOUT_FALL_EDGE;
                  next_st.upd_all = 1'b1;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         st          <= '0;
         st.sclk_d   <= 1'b0;
         st.cs_n_d   <= 1'b1;
         st.shift    <= `RST_SHIFT;
         st.dout     <= `RST_DOUT;
         st.mode     <= dout_mode_e'(`RST_MODE);
         st.user     <= `RST_USER;
         st.shutdown <= `RST_SHUTDOWN;
         st.data     <= `RST_CODE;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ****************************************
   // channel code registers
   // ****************************************
   logic        chan_rst_n;
   logic [31:0] in_codes;
   logic [31:0] dac_codes;

   // clear pin acts without the clock, like power-on
   assign chan_rst_n = arst_n_in & async_clear_n_in;

   channel_regs u_channel_regs
   (
      .clk_in         (clk_in),
      .rst_n_in       (chan_rst_n),
      .ld_one_in      (st.ld_one),
      .ld_all_in      (st.ld_all),
      .upd_all_in     (st.upd_all),
      .transparent_in (~load_strobe_n_s),
      .addr_in        (st.addr),
      .data_in        (st.data),
      .in_code_out    (in_codes),
      .dac_code_out   (dac_codes)
   );

   // output never floats: it is a plain driven level
   assign dout_out       = st.dout;
   assign user_logic_out = st.user;
   assign shutdown_out   = st.shutdown;
   assign dout_mode_out  = st.mode;
   assign dac_code_out   = dac_codes;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in || !async_clear_n_in);

   property p_load_one;
      logic [1:0] a;
      code_t      d;
      (cs_rise && cmd[0], a = cmd_addr, d = cmd_data)
         |-> ##2 in_codes[{a, 3'b000} +: 8] == d;
   endproperty

   property p_load_all;
      code_t d;
      (cs_rise && cmd == `CMD_LOAD_ALL, d = cmd_data)
         |-> ##1 !shutdown_out ##1 dac_codes == {4{d}};
   endproperty

   a_load_one_input: assert property (p_load_one)
      else $error("addressed input code not loaded");

   a_load_keeps_dac: assert property (
      (cs_rise && cmd[1:0] == 2'b01 && load_strobe_n_s)
         ##1 load_strobe_n_s |=> $stable(dac_codes))
      else $error("dac codes changed on input-only load");

   a_load_update_all: assert property (
      (cs_rise && cmd[1:0] == 2'b11) |-> ##2 dac_codes == in_codes)
      else $error("dacs not updated after load and update");

   a_sw_update: assert property (
      (cs_rise && cmd == `CMD_SW_UPDATE)
         |-> ##1 !shutdown_out ##1 dac_codes == in_codes)
      else $error("software update failed");

   a_load_all_chan: assert property (p_load_all)
      else $error("broadcast load failed");

   a_shutdown_gate: assert property (
      (cs_rise && cmd == `CMD_SHUTDOWN)
         |=> shutdown_out == ($past(st.shutdown) || $past(shutdown_permit_s)))
      else $error("shutdown not gated by permit");

   a_pass_quiet: assert property (
      (cs_rise && cmd == `CMD_PASS && load_strobe_n_s)
         ##1 load_strobe_n_s |=> $stable(in_codes) && $stable(dac_codes))
      else $error("pass-through word changed a code");

   a_mode_select: assert property (
      (cs_rise && cmd[3] && cmd[1:0] == 2'b10)
         |=> dout_mode_out == $past(cmd[2]) ##1 dac_codes == in_codes)
      else $error("edge mode command misapplied");

   a_mode_hold: assert property (
      !cs_rise |=> $stable(dout_mode_out))
      else $error("edge mode changed without command");

   a_user_level: assert property (
      (cs_rise && !cmd[3] && cmd[1:0] == 2'b10)
         |=> user_logic_out == $past(cmd[2]))
      else $error("user output wrong level");

   a_idle_hold: assert property (
      cs_n_s |=> $stable(dout_out) && $stable(st.shift))
      else $error("interface moved while deselected");

   a_transparent: assert property (
      (!load_strobe_n_s && $stable(in_codes)) [*2]
         |-> dac_codes == in_codes)
      else $error("dacs not transparent with load strobe low");

   a_shift_in: assert property (
      (!cs_n_s && sclk_rise) |=> st.shift
         == {$past(st.shift[`WORD_BITS-2:0]), $past(din_s)})
      else $error("serial bit not shifted in");

   a_shift_hold: assert property (
      !sclk_rise |=> $stable(st.shift))
      else $error("shift register moved without a clock rise");

   a_dout_rise: assert property (
      (st.mode == DOUT_RISE_EDGE && !cs_n_s && sclk_rise)
         |=> dout_out == $past(st.shift[`WORD_BITS-1]))
      else $error("serial output lag wrong in rising mode");

   a_dout_phase: assert property (
      ((st.mode == DOUT_FALL_EDGE && sclk_rise)
         || (st.mode == DOUT_RISE_EDGE && sclk_fall))
         |=> $stable(dout_out))
      else $error("serial output moved on the wrong edge");

   a_flags_hold: assert property (
      !cs_rise |=> $stable(user_logic_out) && $stable(shutdown_out))
      else $error("user or shutdown output changed without command");

   a_cmd_capture: assert property (
      cs_rise |=> st.addr == $past(cmd_addr) && st.data == $past(cmd_data))
      else $error("command fields not captured");

   a_strobe_pulse: assert property (
      (st.ld_one || st.ld_all || st.upd_all)
         |=> !(st.ld_one || st.ld_all || st.upd_all))
      else $error("decode strobe held longer than one cycle");

   c_load_update: cover property (cs_rise && cmd[1:0] == 2'b11);
   c_load_all: cover property (cs_rise && cmd == `CMD_LOAD_ALL);
   c_shutdown: cover property (cs_rise && cmd == `CMD_SHUTDOWN
                               && shutdown_permit_s);
   c_mode_rise: cover property (cs_rise && cmd == `CMD_MODE_RISE);
   c_user_high: cover property (cs_rise && cmd == `CMD_USER_HIGH);
endmodule

// File: serial_master_model.sv
// serial bus master model that drives the command port link pins
`timescale 1ns/1ps
module serial_master_model
(
   input  wire logic dout_in,
   output logic      sclk_out,
   output logic      din_out,
   output logic      cs_n_out
);
   // ************************************************
   // frame engine, 160 ns serial clock period
   // ************************************************
   logic rise_samp [0:31];
   logic fall_samp [0:31];

   initial
   begin
      sclk_out = 1'b0;
      din_out  = 1'b0;
      cs_n_out = 1'b1;
   end

   // entered at a clk falling edge; all waits keep that phase
   task automatic send(input logic [23:0] word, input int nbits);
      cs_n_out = 1'b0;
      #80;
      for (int i = nbits - 1; i >= 0; i--)
      begin
         din_out = word[i];
         #80;
         rise_samp[nbits-1-i] = dout_in;
         sclk_out = 1'b1;
         #80;
         fall_samp[nbits-1-i] = dout_in;
         sclk_out = 1'b0;
      end
      #80;
      cs_n_out = 1'b1;
      // released data line must not show the last bit
      din_out = ~din_out;
      #200;
   endtask

   // serial clock pulses with select high; must be ignored
   task automatic idle_clocks(input int n);
      for (int i = 0; i < n; i++)
      begin
         din_out = ~din_out;
         #80;
         sclk_out = 1'b1;
         #80;
         sclk_out = 1'b0;
      end
   endtask
endmodule

// File: test_quad_dac_serial_command_port.sv
// self-checking testbench for the quad dac serial command port
`timescale 1ns/1ps
module test_quad_dac_serial_command_port;
   typedef struct packed
   {
      logic [11:0] word;
      logic [1:0]  pins;
      logic [2:0]  flags;
      logic [31:0] dac;
   } row_s;

   logic        clk;
   logic        arst_n;
   logic        sclk;
   logic        din;
   logic        cs_n;
   logic        load_strobe_n;
   logic        async_clear_n;
   logic        shutdown_permit;
   logic        dout;
   logic        user_logic;
   logic        shutdown;
   logic        dout_mode;
   logic [31:0] dac_code;
   logic        held;
   int          n_errors;
   int          checks_done;
   int          cycles;
   row_s        rows [0:20];

   localparam logic [23:0] LAG_WORD = 24'hB4_D05A;

   // ************************************************
   // clock, timeout, design and far side
   // ************************************************
   initial clk = 1'b0;
   always #2.5 clk = ~clk;

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         n_errors++;
         complete_run();
      end
   end

   quad_dac_serial_command_port u_dut
   (
      .clk_in             (clk),
      .arst_n_in          (arst_n),
      .sclk_in            (sclk),
      .din_in             (din),
      .cs_n_in            (cs_n),
      .load_strobe_n_in   (load_strobe_n),
      .async_clear_n_in   (async_clear_n),
      .shutdown_permit_in (shutdown_permit),
      .dout_out           (dout),
      .user_logic_out     (user_logic),
      .shutdown_out       (shutdown),
      .dout_mode_out      (dout_mode),
      .dac_code_out       (dac_code)
   );

   serial_master_model u_master
   (
      .dout_in  (dout),
      .sclk_out (sclk),
      .din_out  (din),
      .cs_n_out (cs_n)
   );

   // ************************************************
   // shared tasks
   // ************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want)
      begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic frame(input logic [23:0] word, input int nbits);
      @(negedge clk);
      u_master.send(word, nbits);
   endtask

   task automatic do_reset();
      @(negedge clk);
      arst_n = 1'b0;
      repeat (16) @(negedge clk);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      check({28'h0, dout, user_logic, shutdown, dout_mode}, 32'h0);
      check(dac_code, 32'h0);
      $display("reset test done");
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ************************************************
   // main sequence
   // ************************************************
   initial
   begin
      arst_n = 1'b0;
      load_strobe_n = 1'b1;
      async_clear_n = 1'b1;
      shutdown_permit = 1'b0;
      n_errors = 0;
      checks_done = 0;
      cycles = 0;
      rows = '{
         '{12'h111, 2'b10, 3'b000, 32'h0000_0000},
         '{12'h522, 2'b10, 3'b000, 32'h0000_0000},
         '{12'h933, 2'b10, 3'b000, 32'h0000_0000},
         '{12'hF44, 2'b10, 3'b000, 32'h4433_2211},
         '{12'h155, 2'b10, 3'b000, 32'h4433_2211},
         '{12'h4FF, 2'b10, 3'b000, 32'h4433_2255},
         '{12'hC00, 2'b10, 3'b000, 32'h4433_2255},
         '{12'hC00, 2'b11, 3'b010, 32'h4433_2255},
         '{12'h400, 2'b11, 3'b000, 32'h4433_2255},
         '{12'hCFF, 2'b11, 3'b010, 32'h4433_2255},
         '{12'h8A5, 2'b11, 3'b000, 32'hA5A5_A5A5},
         '{12'h699, 2'b10, 3'b100, 32'hA5A5_A5A5},
         '{12'h2FF, 2'b10, 3'b000, 32'hA5A5_A5A5},
         '{12'h766, 2'b10, 3'b000, 32'hA5A5_66A5},
         '{12'h177, 2'b00, 3'b000, 32'hA5A5_6677},
         '{12'h112, 2'b10, 3'b000, 32'hA5A5_6677},
         '{12'hE00, 2'b10, 3'b001, 32'hA5A5_6612},
         '{12'h0FF, 2'b10, 3'b001, 32'hA5A5_6612},
         '{12'h134, 2'b10, 3'b001, 32'hA5A5_6612},
         '{12'hA00, 2'b10, 3'b000, 32'hA5A5_6634},
         '{12'hB5A, 2'b10, 3'b000, 32'hA55A_6634}};
      do_reset();
      for (int i = 0; i <= 20; i++)
      begin
         @(negedge clk);
         {load_strobe_n, shutdown_permit} = rows[i].pins;
         frame({12'h000, rows[i].word}, 12);
         check(dac_code, rows[i].dac);
         check({29'h0, user_logic, shutdown, dout_mode},
               {29'h0, rows[i].flags});
         $display("row %0d done", i);
      end
      // leading four bits of a 16-bit word drop out
      frame(24'h00_F3CD, 16);
      check(dac_code, 32'hA55A_66CD);
      $display("long word test done");
      // loop-back lag in both output edge modes
      frame(LAG_WORD, 24);
      for (int k = 0; k < 11; k++)
      begin
         check({31'h0, u_master.rise_samp[k+13]},
               {31'h0, LAG_WORD[23-k]});
         check({31'h0, u_master.fall_samp[k+13]},
               {31'h0, LAG_WORD[23-k]});
      end
      frame(24'h00_0E00, 12);
      frame(LAG_WORD, 24);
      for (int k = 0; k < 12; k++)
         check({31'h0, u_master.fall_samp[k+12]},
               {31'h0, LAG_WORD[23-k]});
      check({31'h0, dout_mode}, 32'h1);
      $display("output lag test done");
      // clocks with select high change nothing
      held = dout;
      @(negedge clk);
      u_master.idle_clocks(12);
      repeat (8) @(negedge clk);
      check({31'h0, dout}, {31'h0, held});
      check(dac_code, 32'hA55A_66CD);
      $display("deselected test done");
      // clear pin wipes codes only
      @(negedge clk);
      async_clear_n = 1'b0;
      repeat (3) @(negedge clk);
      check(dac_code, 32'h0);
      async_clear_n = 1'b1;
      repeat (3) @(negedge clk);
      check({31'h0, dout_mode}, 32'h1);
      $display("clear test done");
      do_reset();
      complete_run();
   end
endmodule
